//--- hw/fmr_modem_ctrl.sv
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// - mode pins 00 rx+75 tx, 01 1200 tx only, 10 rx only, 11 sleep.
// - sleep mode holds the retiming logic in reset and disables the oscillator.
// - equalizer pin low gives flat delay, high switches equalizer in while receiver on.
// - energy detect rises only after sustained level, with hysteresis.
// - without rx retiming, demodulated data drives rx output directly.
// - receiver off or sleep holds energy detect and rx data low.
// - tone chosen from mode and tx bit; rx-only mode gives mid rail.
// - rx retiming captures nine bits after each start, read by strobe.
// - two nine-bit registers; first filled after falling start edge.
// - ninth bit copies all bits across unless a readout is active, restarts search, samples strobe.
// - strobe low at completion asserts ready and shows first bit.
// - nine strobe pulses; first eight falls shift, ninth ends readout.
// - ready released on first strobe rise after it was asserted.
// - strobe held high means direct data and no receive ready.
// - tx retiming uses two bit registers; second loads on 1200Hz tick.
// - tick with strobe high passes pin, low uses register and readies.
// - high strobe releases ready; strobe rise latches tx data pin.
module fmr_modem_ctrl
  import fmr_pkg::*;
#(
  parameter int BIT_CYC  = BIT_CYC_DEF,
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter int DET_ON   = DET_ON_DEF,
  parameter int DET_OFF  = DET_OFF_DEF
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // controller pins
  input  wire logic        mode_select_lo_i,
  input  wire logic        mode_select_hi_i,
  input  wire logic        equalizer_select_i,
  input  wire logic        strobe_i,
  input  wire logic        txd_i,
  input  wire logic        ready_n_i,
  output logic             ready_n_o,
  output logic             ready_n_oe_o,
  output logic             rxd_o,
  output logic             energy_detect_o,
  // analog front end
  input  wire logic        demod_data_i,
  input  wire logic        level_on_i,
  input  wire logic        level_hold_i,
  output logic             sleep_state_o,
  output logic             osc_enable_o,
  output logic             eq_enable_o,
  output fmr_tone_t        tone_out_o
);

  localparam int BW = $clog2(BIT_CYC + 1);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int DW = $clog2(DET_ON + DET_OFF + 1);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  fmr_pins_t pin_raw, pin_s1_r, pin_s2_r;
  logic      strobe_d_r, ready_s1_r, ready_s2_r;
  fmr_mode_t mode;
  logic      strobe_rise, strobe_fall, sleep;

  assign pin_raw = '{mode_select_lo: mode_select_lo_i, mode_select_hi: mode_select_hi_i,
                     equalizer_select: equalizer_select_i, strobe: strobe_i, txd: txd_i,
                     demod: demod_data_i, level_on: level_on_i, level_hold: level_hold_i};

  always_ff @(posedge mclk_i) begin
    pin_s1_r   <= pin_raw;
    pin_s2_r   <= pin_s1_r;
    strobe_d_r <= pin_s2_r.strobe;
    ready_s1_r <= ready_n_i;
    ready_s2_r <= ready_s1_r;
  end

  assign mode        = fmr_mode_t'({pin_s2_r.mode_select_hi, pin_s2_r.mode_select_lo});
  assign sleep       = (mode == MODE_SLEEP);
  assign strobe_rise = pin_s2_r.strobe & ~strobe_d_r;
  assign strobe_fall = ~pin_s2_r.strobe & strobe_d_r;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt, status;
  logic        rx_rdy_r, tx_rdy_r, rd_active_r, det_r, rxd_r;

  always_comb begin
    status = 32'h0;
    status[ST_MODE_LSB +: 2] = mode;
    status[ST_DET_BIT]       = det_r;
    status[ST_RDY_BIT]       = rx_rdy_r | tx_rdy_r;
    status[ST_RXD_BIT]       = rxd_r;
    status[ST_READ_BIT]      = rd_active_r;
    status[ST_EQ_BIT]        = pin_s2_r.equalizer_select;
    status[ST_PIN_BIT]       = ready_s2_r;
    ctrl_nxt  = ctrl_r;
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read_i | avs_write_i) & wait_r) begin
      wait_nxt = 1'b0;
      if (avs_write_i && avs_address_i == REG_CTRL_ADDR && avs_byteenable_i[0]) begin
        ctrl_nxt = avs_writedata_i[1:0];
      end
      if (avs_read_i) begin
        case (avs_address_i)
          REG_CTRL_ADDR:   rdata_nxt = {30'h0, ctrl_r};
          REG_STATUS_ADDR: rdata_nxt = status;
          default:         rdata_nxt = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_r  <= CTRL_RESET;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // energy detector
  // ------------------------------------------------------------
  logic          det_nxt;
  logic [DW-1:0] det_cnt_r, det_cnt_nxt;
  logic          rx_on;

  assign rx_on = (mode == MODE_RX_TX75) | (mode == MODE_RX_ONLY);

  always_comb begin
    det_nxt     = det_r;
    det_cnt_nxt = '0;
    if (!rx_on) begin
      det_nxt = 1'b0;
    end else if (!det_r) begin
      if (pin_s2_r.level_on) begin
        det_cnt_nxt = det_cnt_r + DW'(1);
        if (det_cnt_r == DW'(DET_ON - 1)) begin
          det_nxt     = 1'b1;
          det_cnt_nxt = '0;
        end
      end
    end else if (!pin_s2_r.level_hold) begin
      det_cnt_nxt = det_cnt_r + DW'(1);
      if (det_cnt_r == DW'(DET_OFF - 1)) begin
        det_nxt     = 1'b0;
        det_cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      det_r     <= 1'b0;
      det_cnt_r <= '0;
    end else begin
      det_r     <= det_nxt;
      det_cnt_r <= det_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // receive retiming
  // ------------------------------------------------------------
  fmr_rx_state_t         rx_st_r, rx_st_nxt;
  logic [BW-1:0]         rx_cnt_r, rx_cnt_nxt;
  logic [3:0]            nbits_r, nbits_nxt, falls_r, falls_nxt;
  logic [RX_NBITS-1:0]   sr1_r, sr1_nxt, sr2_r, sr2_nxt;
  logic                  rx_rdy_nxt, rd_active_nxt, char_done, rx_ret;

  assign rx_ret = rx_on & ctrl_r[CTRL_RX_RETIME_BIT];

  always_comb begin
    rx_st_nxt     = rx_st_r;
    rx_cnt_nxt    = rx_cnt_r + BW'(1);
    nbits_nxt     = nbits_r;
    sr1_nxt       = sr1_r;
    sr2_nxt       = sr2_r;
    falls_nxt     = falls_r;
    rx_rdy_nxt    = rx_rdy_r;
    rd_active_nxt = rd_active_r;
    char_done     = 1'b0;
    case (rx_st_r)
      RX_WAIT_HIGH: if (pin_s2_r.demod) rx_st_nxt = RX_HUNT;
      RX_HUNT: begin
        rx_cnt_nxt = '0;
        if (!pin_s2_r.demod) rx_st_nxt = RX_START;
      end
      RX_START: begin
        if (rx_cnt_r == BW'(BIT_CYC / 2 - 1)) begin
          rx_cnt_nxt = '0;
          nbits_nxt  = 4'h0;
          rx_st_nxt  = pin_s2_r.demod ? RX_WAIT_HIGH : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_cnt_r == BW'(BIT_CYC - 1)) begin
          rx_cnt_nxt = '0;
          sr1_nxt    = {pin_s2_r.demod, sr1_r[RX_NBITS-1:1]};
          nbits_nxt  = nbits_r + 4'h1;
          if (nbits_r == 4'(RX_NBITS - 1)) begin
            char_done = 1'b1;
            rx_st_nxt = RX_WAIT_HIGH;
          end
        end
      end
      default: rx_st_nxt = RX_WAIT_HIGH;
    endcase
    if (rd_active_r) begin
      if (strobe_rise) rx_rdy_nxt = 1'b0;
      if (strobe_fall) begin
        falls_nxt = falls_r + 4'h1;
        if (falls_r == 4'(RX_NBITS - 1)) begin
          rd_active_nxt = 1'b0;
        end else begin
          sr2_nxt = {1'b0, sr2_r[RX_NBITS-1:1]};
        end
      end
    end else if (char_done) begin
      sr2_nxt = sr1_nxt;
      if (!pin_s2_r.strobe) begin
        rx_rdy_nxt    = 1'b1;
        rd_active_nxt = 1'b1;
        falls_nxt     = 4'h0;
      end
    end
    if (!rx_ret) begin
      rx_st_nxt     = RX_WAIT_HIGH;
      rx_rdy_nxt    = 1'b0;
      rd_active_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || sleep) begin
      rx_st_r     <= RX_WAIT_HIGH;
      rx_cnt_r    <= '0;
      nbits_r     <= 4'h0;
      falls_r     <= 4'h0;
      sr1_r       <= '0;
      sr2_r       <= '0;
      rx_rdy_r    <= 1'b0;
      rd_active_r <= 1'b0;
    end else begin
      rx_st_r     <= rx_st_nxt;
      rx_cnt_r    <= rx_cnt_nxt;
      nbits_r     <= nbits_nxt;
      falls_r     <= falls_nxt;
      sr1_r       <= sr1_nxt;
      sr2_r       <= sr2_nxt;
      rx_rdy_r    <= rx_rdy_nxt;
      rd_active_r <= rd_active_nxt;
    end
  end

  // ------------------------------------------------------------
  // transmit retiming
  // ------------------------------------------------------------
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic          tx_reg1_r, tx_reg1_nxt, tx_reg2_r, tx_reg2_nxt;
  logic          tx_direct_r, tx_direct_nxt, tx_rdy_nxt, tick, tx_ret, mod_bit;

  assign tx_ret = (mode == MODE_TX1200) & ctrl_r[CTRL_TX_RETIME_BIT];
  assign tick   = (tick_cnt_r == TW'(TICK_CYC - 1));

  always_comb begin
    tick_cnt_nxt  = tick ? '0 : tick_cnt_r + TW'(1);
    tx_reg1_nxt   = strobe_rise ? pin_s2_r.txd : tx_reg1_r;
    tx_reg2_nxt   = tx_reg2_r;
    tx_direct_nxt = tx_direct_r;
    tx_rdy_nxt    = tx_rdy_r;
    if (pin_s2_r.strobe) tx_rdy_nxt = 1'b0;
    if (tick) begin
      tx_direct_nxt = pin_s2_r.strobe;
      if (!pin_s2_r.strobe) begin
        tx_reg2_nxt = tx_reg1_r;
        tx_rdy_nxt  = 1'b1;
      end
    end
    if (!tx_ret) begin
      tx_direct_nxt = 1'b1;
      tx_rdy_nxt    = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || sleep) begin
      tick_cnt_r  <= '0;
      tx_reg1_r   <= 1'b1;
      tx_reg2_r   <= 1'b1;
      tx_direct_r <= 1'b1;
      tx_rdy_r    <= 1'b0;
    end else begin
      tick_cnt_r  <= tick_cnt_nxt;
      tx_reg1_r   <= tx_reg1_nxt;
      tx_reg2_r   <= tx_reg2_nxt;
      tx_direct_r <= tx_direct_nxt;
      tx_rdy_r    <= tx_rdy_nxt;
    end
  end

  assign mod_bit = tx_direct_r ? pin_s2_r.txd : tx_reg2_r;

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  logic      rxd_nxt, rdy_oe_r, rdy_oe_nxt, sleep_r, osc_r, eq_r, eq_nxt;
  fmr_tone_t tone_r, tone_nxt;

  always_comb begin
    rxd_nxt    = rd_active_r ? sr2_r[0] : pin_s2_r.demod;
    if (!rx_on) rxd_nxt = 1'b0;
    rdy_oe_nxt = rx_rdy_r | tx_rdy_r;
    eq_nxt     = rx_on & pin_s2_r.equalizer_select;
    case (mode)
      MODE_RX_TX75: tone_nxt = mod_bit ? TONE_390HZ : TONE_450HZ;
      MODE_TX1200:  tone_nxt = mod_bit ? TONE_1300HZ : TONE_2100HZ;
      default:      tone_nxt = TONE_MID_RAIL;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rxd_r    <= 1'b0;
      rdy_oe_r <= 1'b0;
      eq_r     <= 1'b0;
      tone_r   <= TONE_MID_RAIL;
      sleep_r  <= 1'b0;
      osc_r    <= 1'b0;
    end else begin
      rxd_r    <= rxd_nxt;
      rdy_oe_r <= rdy_oe_nxt;
      eq_r     <= eq_nxt;
      tone_r   <= tone_nxt;
      sleep_r  <= sleep;
      osc_r    <= ~sleep;
    end
  end

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign ready_n_o         = 1'b0;
  assign ready_n_oe_o      = rdy_oe_r;
  assign rxd_o             = rxd_r;
  assign energy_detect_o   = det_r;
  assign sleep_state_o     = sleep_r;
  assign osc_enable_o      = osc_r;
  assign eq_enable_o       = eq_r;
  assign tone_out_o        = tone_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  chk_sleep_osc_off: assert property (sleep |=> sleep_state_o && !osc_enable_o)
    else $error("sleep mode did not stop oscillator");
  chk_rx_off_low: assert property (!rx_on |=> !rxd_o && !energy_detect_o)
    else $error("rx outputs not low with receiver off");
  chk_direct_rxd: assert property (rx_on && !rd_active_r |=> rxd_o == $past(pin_s2_r.demod))
    else $error("rx data not following demodulator");
  chk_eq_follow: assert property (rx_on |=> eq_enable_o == $past(pin_s2_r.equalizer_select))
    else $error("equalizer select not followed");
  chk_tone_low_ch: assert property (mode == MODE_RX_TX75 && !mod_bit |=> tone_out_o == TONE_450HZ)
    else $error("wrong back channel space tone");
  chk_char_ready: assert property (char_done && rx_ret && !rd_active_r && !pin_s2_r.strobe |=>
    rd_active_r && rx_rdy_r ##1 ready_n_oe_o && rxd_o == sr2_r[0])
    else $error("character completion did not assert ready");
  chk_rdy_release: assert property (rd_active_r && strobe_rise |=> !rx_rdy_r)
    else $error("ready not released on strobe rise");
  chk_ninth_fall: assert property (rd_active_r && strobe_fall && falls_r == 4'h8 && rx_ret |=>
    !rd_active_r ##1 rxd_o == $past(pin_s2_r.demod))
    else $error("readout did not end after ninth pulse");
  chk_tx_tick_load: assert property (tx_ret && tick && !pin_s2_r.strobe |=>
    tx_rdy_r && !tx_direct_r && tx_reg2_r == $past(tx_reg1_r))
    else $error("tx tick did not load second register");
  chk_det_sustain: assert property ($rose(det_r) |-> $past(pin_s2_r.level_on))
    else $error("energy detect rose without level");
  chk_bus_answer: assert property ((avs_read_i || avs_write_i) && wait_r |=> !wait_r ##1 wait_r)
    else $error("bus answer not one cycle");

  cov_rx_char: cover property (char_done && !pin_s2_r.strobe);
  cov_rx_readout: cover property (rd_active_r && strobe_fall && falls_r == 4'h8);
  cov_tx_ready: cover property (tx_ret && tick && !pin_s2_r.strobe);
  cov_det_rise: cover property ($rose(det_r));

endmodule : fmr_modem_ctrl

//--- pkg/fmr_pkg.sv
package fmr_pkg;

  // ------------------------------------------------------------
  // clocking and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ      = 100_000_000;
  localparam int RX_BAUD     = 1200;
  localparam int TX_TICK_HZ  = 1200;
  localparam int DET_ON_MS   = 25;
  localparam int DET_OFF_MS  = 8;
  localparam int CYC_PER_MS  = CLK_HZ / 1000;
  localparam int BIT_CYC_DEF = CLK_HZ / RX_BAUD;
  localparam int TICK_CYC_DEF = CLK_HZ / TX_TICK_HZ;
  localparam int DET_ON_DEF  = DET_ON_MS * CYC_PER_MS;
  localparam int DET_OFF_DEF = DET_OFF_MS * CYC_PER_MS;
  localparam int RX_NBITS    = 9;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
  localparam logic [1:0] CTRL_RESET      = 2'h0;
  localparam int CTRL_RX_RETIME_BIT = 0;
  localparam int CTRL_TX_RETIME_BIT = 1;
  localparam int ST_MODE_LSB   = 0;
  localparam int ST_DET_BIT    = 2;
  localparam int ST_RDY_BIT    = 3;
  localparam int ST_RXD_BIT    = 4;
  localparam int ST_READ_BIT   = 5;
  localparam int ST_EQ_BIT     = 6;
  localparam int ST_PIN_BIT    = 7;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RX_TX75  = 2'h0,
    MODE_TX1200   = 2'h1,
    MODE_RX_ONLY  = 2'h2,
    MODE_SLEEP    = 2'h3
  } fmr_mode_t;

  typedef enum logic [2:0] {
    TONE_MID_RAIL = 3'h0,
    TONE_450HZ    = 3'h1,
    TONE_390HZ    = 3'h2,
    TONE_2100HZ   = 3'h3,
    TONE_1300HZ   = 3'h4
  } fmr_tone_t;

  typedef enum logic [1:0] {
    RX_WAIT_HIGH = 2'h0,
    RX_HUNT      = 2'h1,
    RX_START     = 2'h2,
    RX_DATA      = 2'h3
  } fmr_rx_state_t;

  typedef struct packed {
    logic mode_select_lo;
    logic mode_select_hi;
    logic equalizer_select;
    logic strobe;
    logic txd;
    logic demod;
    logic level_on;
    logic level_hold;
  } fmr_pins_t;

endpackage : fmr_pkg

//--- testbench/fmr_modem_ctrl_tb.sv
`timescale 1ns/100ps
module fmr_modem_ctrl_tb
  import fmr_pkg::*;
;
  localparam int BITC = 40;
  logic        mclk_i = 1'b0;
  logic        rstn_i;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        eq_sel;
  logic        demod;
  logic        lvl_on;
  logic        lvl_hold;
  logic        mode_lo, mode_hi, strobe, txd, ready_n_o, ready_n_oe_o;
  logic        rxd_o, energy_detect_o, sleep_state_o, osc_enable_o, eq_enable_o;
  wire         ready_pin;
  fmr_tone_t   tone_out_o;
  int          num_errors = 0;
  int          num_checks = 0;

  assign ready_pin = ready_n_oe_o ? ready_n_o : 1'b1; // pull-up on the wire
  always #5 mclk_i = ~mclk_i;

  fmr_modem_ctrl #(.BIT_CYC(BITC), .TICK_CYC(40), .DET_ON(20), .DET_OFF(10)) fmr_modem_ctrl_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .mode_select_lo_i(mode_lo), .mode_select_hi_i(mode_hi), .equalizer_select_i(eq_sel),
    .strobe_i(strobe), .txd_i(txd), .ready_n_i(ready_pin), .ready_n_o(ready_n_o),
    .ready_n_oe_o(ready_n_oe_o), .rxd_o(rxd_o), .energy_detect_o(energy_detect_o),
    .demod_data_i(demod), .level_on_i(lvl_on), .level_hold_i(lvl_hold), .sleep_state_o(sleep_state_o),
    .osc_enable_o(osc_enable_o), .eq_enable_o(eq_enable_o), .tone_out_o(tone_out_o));

  fmr_uc_model uc_i (.mclk_i(mclk_i), .ready_n_i(ready_pin), .rxd_i(rxd_o), .mode_select_lo_o(mode_lo),
    .mode_select_hi_o(mode_hi), .strobe_o(strobe), .txd_o(txd));

  // ----------------------------------------
  // compare and bus helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_tone(input fmr_tone_t got, input fmr_tone_t exp);
    chk(32'(got), 32'(exp));
  endtask : chk_tone

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic send_char(input logic [8:0] c);
    @(posedge mclk_i);
    demod <= 1'b0;
    repeat (BITC) @(posedge mclk_i);
    for (int i = 0; i < 9; i++) begin
      demod <= c[i];
      repeat (BITC) @(posedge mclk_i);
    end
    demod <= 1'b1;
    repeat (2 * BITC) @(posedge mclk_i);
  endtask : send_char

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs;
    logic [31:0] d;
    uc_i.set_mode(MODE_RX_TX75);
    bus(0, REG_CTRL_ADDR, 32'h0, d);
    chk(d, 32'(CTRL_RESET));
    bus(1, 4'h8, 32'hffffffff, d);
    bus(0, 4'h8, 32'h0, d);
    chk(d, 32'h0);
    bus(1, REG_CTRL_ADDR, 32'hffffffff, d);
    bus(0, REG_CTRL_ADDR, 32'h0, d);
    chk(d, 32'h3);
    avs_byteenable_i <= 4'he;
    bus(1, REG_CTRL_ADDR, 32'h0, d);
    avs_byteenable_i <= 4'hf;
    bus(0, REG_CTRL_ADDR, 32'h0, d);
    chk(d, 32'h3);
    bus(1, REG_CTRL_ADDR, 32'h0, d);
    eq_sel <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk(eq_enable_o, 1'b1);
    eq_sel <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk(eq_enable_o, 1'b0);
  endtask : test_regs

  task automatic test_modes;
    logic [31:0] d;
    fmr_tone_t   exp_t [4][2];
    exp_t = '{'{TONE_450HZ, TONE_390HZ}, '{TONE_2100HZ, TONE_1300HZ},
              '{TONE_MID_RAIL, TONE_MID_RAIL}, '{TONE_MID_RAIL, TONE_MID_RAIL}};
    for (int m = 0; m < 4; m++) begin
      uc_i.set_mode(fmr_mode_t'(m));
      bus(0, REG_STATUS_ADDR, 32'h0, d);
      chk(d[1:0], m[1:0]);
      chk(sleep_state_o, m == 3);
      chk(osc_enable_o, m != 3);
      chk(rxd_o, m[0] == 1'b0);
      for (int t = 0; t < 2; t++) begin
        uc_i.set_txd(t[0]);
        chk_tone(tone_out_o, exp_t[m][t]);
      end
    end
  endtask : test_modes

  task automatic test_energy;
    uc_i.set_mode(MODE_RX_TX75);
    lvl_hold <= 1'b1;
    lvl_on <= 1'b1;
    repeat (15) @(posedge mclk_i);
    lvl_on <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk(energy_detect_o, 1'b0);
    lvl_on <= 1'b1;
    repeat (30) @(posedge mclk_i);
    chk(energy_detect_o, 1'b1);
    lvl_on <= 1'b0;
    lvl_hold <= 1'b0;
    repeat (6) @(posedge mclk_i);
    lvl_hold <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk(energy_detect_o, 1'b1);
    lvl_hold <= 1'b0;
    repeat (20) @(posedge mclk_i);
    chk(energy_detect_o, 1'b0);
    lvl_on <= 1'b1;
    lvl_hold <= 1'b1;
    uc_i.set_mode(MODE_TX1200);
    repeat (30) @(posedge mclk_i);
    chk(energy_detect_o, 1'b0);
    lvl_on <= 1'b0;
    lvl_hold <= 1'b0;
  endtask : test_energy

  task automatic test_rx_retime;
    logic [31:0] d;
    logic [8:0]  got;
    logic        ok;
    logic        r;
    logic [8:0]  chars [2];
    chars = '{9'h0a5, 9'h03c};
    uc_i.set_mode(MODE_RX_TX75);
    bus(1, REG_CTRL_ADDR, 32'h1, d);
    for (int k = 0; k < 2; k++) begin
      uc_i.set_strobe(1'b0);
      send_char(chars[k]);
      uc_i.wait_ready(ok);
      chk(ok, 1'b1);
      uc_i.read_char(got, r);
      chk(got, chars[k]);
      chk(r, 1'b1);
      chk(rxd_o, 1'b1);
    end
    uc_i.set_strobe(1'b1);
    send_char(9'h000);
    chk(ready_n_oe_o, 1'b0);
    bus(1, REG_CTRL_ADDR, 32'h0, d);
  endtask : test_rx_retime

  task automatic test_tx_retime;
    logic [31:0] d;
    logic        ok;
    logic        r;
    logic [4:0]  bits;
    bits = 5'b01101;
    uc_i.set_mode(MODE_TX1200);
    uc_i.set_txd(1'b1);
    bus(1, REG_CTRL_ADDR, 32'h2, d);
    uc_i.set_strobe(1'b0);
    for (int i = 0; i < 6; i++) begin
      uc_i.wait_ready(ok);
      chk(ok, 1'b1);
      repeat (3) @(posedge mclk_i);
      if (i > 0) chk_tone(tone_out_o, bits[i-1] ? TONE_1300HZ : TONE_2100HZ);
      if (i < 5) begin
        uc_i.send_bit(bits[i], r);
        chk(r, 1'b1);
      end
    end
    uc_i.set_strobe(1'b1);
    repeat (80) @(posedge mclk_i);
    uc_i.set_txd(1'b1);
    repeat (45) @(posedge mclk_i);
    chk_tone(tone_out_o, TONE_1300HZ);
    bus(1, REG_CTRL_ADDR, 32'h0, d);
  endtask : test_tx_retime

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    rstn_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    eq_sel = 1'b0;
    demod = 1'b1;
    lvl_on = 1'b0;
    lvl_hold = 1'b0;
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    test_regs();
    test_modes();
    test_energy();
    test_rx_retime();
    test_tx_retime();
    tally_and_finish();
  end

  initial begin
    #500000;
    num_errors++;
    tally_and_finish();
  end
endmodule : fmr_modem_ctrl_tb

//--- testbench/fmr_uc_model.sv
`timescale 1ns/100ps
module fmr_uc_model
  import fmr_pkg::*;
#(
  parameter int WAKE_CYC = 20
) (
  // clock
  input  wire logic mclk_i,
  // modem pins seen by the controller
  input  wire logic ready_n_i,
  input  wire logic rxd_i,
  output logic      mode_select_lo_o,
  output logic      mode_select_hi_o,
  output logic      strobe_o,
  output logic      txd_o
);
  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  initial begin
    mode_select_lo_o = 1'b1; // powers up asleep
    mode_select_hi_o = 1'b1;
    strobe_o         = 1'b1; // idle high, no retiming
    txd_o            = 1'b1;
  end

  task automatic set_mode(input fmr_mode_t m);
    @(posedge mclk_i);
    {mode_select_hi_o, mode_select_lo_o} <= m;
    repeat (WAKE_CYC) @(posedge mclk_i); // settle before data
  endtask : set_mode

  task automatic set_strobe(input logic s);
    @(posedge mclk_i);
    strobe_o <= s; // held at the given level until set again
    repeat (5) @(posedge mclk_i);
  endtask : set_strobe

  task automatic set_txd(input logic b);
    @(posedge mclk_i);
    txd_o <= b;
    repeat (5) @(posedge mclk_i);
  endtask : set_txd

  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (ready_n_i !== 1'b0 && n < 2000) begin
      @(posedge mclk_i);
      n++;
    end
    ok = (ready_n_i === 1'b0);
  endtask : wait_ready

  // one short strobe pulse, high for six clocks; r is the ready pin late in the high phase
  task automatic pulse(output logic r);
    @(posedge mclk_i);
    strobe_o <= 1'b1;
    repeat (6) @(posedge mclk_i);
    r = ready_n_i;
    strobe_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
  endtask : pulse

  task automatic read_char(output logic [8:0] d, output logic r1);
    logic r;
    d[0] = rxd_i;
    pulse(r1); // nine pulses, well inside a character
    for (int i = 1; i < 9; i++) begin
      d[i] = rxd_i;
      pulse(r);
    end
  endtask : read_char

  task automatic send_bit(input logic b, output logic r);
    @(posedge mclk_i);
    txd_o <= b; // next bit after ready, then pulse
    pulse(r);
  endtask : send_bit
endmodule : fmr_uc_model
